// ===== hw/dcev_pkg.sv
// Package for the DMA channel event control block: constants and carrier types
package dcev_pkg;

  // Event output cause select encodings
  localparam logic [1:0] EVO_CAUSE_NONE = 2'h0;
  localparam logic [1:0] EVO_CAUSE_BLOCK = 2'h1;
  localparam logic [1:0] EVO_CAUSE_BEAT = 2'h3;

  // Channel count and number of channels that carry an event output
  localparam int unsigned NUM_CHANNELS = 12;
  localparam int unsigned NUM_EVOUT_CHANNELS = 4;

  // Reset values
  localparam logic RST_SUSPENDED = 1'b0;
  localparam logic RST_SKIP_PEND = 1'b0;

  // Per-channel input action select encodings
  localparam logic [1:0] EVIN_ACT_NONE = 2'h0;
  localparam logic [1:0] EVIN_ACT_SUSPEND = 2'h1;
  localparam logic [1:0] EVIN_ACT_RESUME = 2'h2;
  localparam logic [1:0] EVIN_ACT_SKIP = 2'h3;

  // Channel suspend state, Gray coded
  typedef enum logic [1:0] {
    DCEV_RUN = 2'b00,
    DCEV_CHANNEL_SUSPEND_FLAG_WAIT = 2'b01,
    DCEV_SUSPENDED = 2'b11
  } dcev_state_t;

  // Transfer progress reported by the channel datapath
  typedef struct packed {
    logic bus_busy;
    logic beat_done;
    logic block_done;
    logic block_suspend;
  } dcev_xfer_t;

  // Per-channel configuration from the descriptor and control registers
  typedef struct packed {
    logic [1:0] evin_act;
    logic channel_event_output_enable;
    logic [1:0] event_output_cause_select;
  } dcev_cfg_t;

endpackage

// ===== hw/dcev_chan.sv
// One channel's event input action and event output pulse logic
`timescale 1ns/10ps
`default_nettype none

module dcev_chan #(
  parameter bit HAS_EVOUT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ev_in,
  input wire dcev_pkg::dcev_cfg_t cfg,
  input wire dcev_pkg::dcev_xfer_t xfer,
  output logic ev_ack,
  output logic channel_suspend_flag_flag,
  output logic suspended,
  output logic hold_req,
  output logic ev_out
);

  dcev_pkg::dcev_state_t state_r;
  logic skip_pend_r;
  logic channel_suspend_flag_flag_r;
  logic ev_out_r;
  logic ack_r;
  logic ev_channel_suspend_flag;
  logic ev_res;
  logic ev_skip;
  logic skip_hit;
  logic channel_suspend_flag_done;
  logic blk_channel_suspend_flag_hit;
  logic skip_now;
  logic enter_channel_suspend_flag;

  // Decode the incoming event by the channel's input action
  assign ev_channel_suspend_flag = ev_in && (cfg.evin_act == dcev_pkg::EVIN_ACT_SUSPEND);
  assign ev_res = ev_in && (cfg.evin_act == dcev_pkg::EVIN_ACT_RESUME);
  assign ev_skip = ev_in && (cfg.evin_act == dcev_pkg::EVIN_ACT_SKIP);
  // Pending skip meets a block suspend detection
  assign skip_hit = skip_pend_r && xfer.block_suspend;
  // Suspend request reaches bus idle while waiting
  assign channel_suspend_flag_done = (state_r == dcev_pkg::DCEV_CHANNEL_SUSPEND_FLAG_WAIT) && !xfer.bus_busy
                     && !ev_res && !ev_skip;
  // Block suspend detected with no skip pending or arriving
  assign blk_channel_suspend_flag_hit = (state_r == dcev_pkg::DCEV_RUN) && !ev_channel_suspend_flag && xfer.block_suspend
                        && !skip_pend_r && !ev_skip;
  // Skip arriving in the very cycle of a block suspend is used at once
  assign skip_now = ev_skip && (state_r == dcev_pkg::DCEV_RUN) && xfer.block_suspend
                    && !skip_pend_r;
  assign enter_channel_suspend_flag = channel_suspend_flag_done || blk_channel_suspend_flag_hit;

  // Suspend state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= dcev_pkg::DCEV_RUN;
    end else begin
      case (state_r)
        dcev_pkg::DCEV_RUN: begin
          if (ev_channel_suspend_flag) begin
            state_r <= dcev_pkg::DCEV_CHANNEL_SUSPEND_FLAG_WAIT;
          end else if (xfer.block_suspend && !skip_pend_r && !ev_skip) begin
            state_r <= dcev_pkg::DCEV_SUSPENDED;
          end
        end
        dcev_pkg::DCEV_CHANNEL_SUSPEND_FLAG_WAIT: begin
          if (ev_res || ev_skip) begin
            state_r <= dcev_pkg::DCEV_RUN;
          end else if (!xfer.bus_busy) begin
            state_r <= dcev_pkg::DCEV_SUSPENDED;
          end
        end
        dcev_pkg::DCEV_SUSPENDED: begin
          if (ev_res || ev_skip) begin
            state_r <= dcev_pkg::DCEV_RUN;
          end
        end
        default: state_r <= dcev_pkg::DCEV_RUN;
      endcase
    end
  end

  // Skip held until the next block suspend detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_pend_r <= dcev_pkg::RST_SKIP_PEND;
    end else if (ev_skip && (state_r == dcev_pkg::DCEV_RUN) && !skip_now) begin
      skip_pend_r <= 1'b1;
    end else if (skip_hit) begin
      skip_pend_r <= 1'b0;
    end
  end

  // Suspend interrupt flag: entering suspend wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_suspend_flag_flag_r <= dcev_pkg::RST_SUSPENDED;
    end else if (enter_channel_suspend_flag) begin
      channel_suspend_flag_flag_r <= 1'b1;
    end else if (ev_res || (ev_skip && state_r != dcev_pkg::DCEV_RUN)) begin
      channel_suspend_flag_flag_r <= 1'b0;
    end
  end

  // Acknowledge pulse: suspend after bus idle, resume at once, skip when used
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= channel_suspend_flag_done
               || ev_res
               || (ev_skip && state_r != dcev_pkg::DCEV_RUN)
               || skip_hit
               || skip_now;
    end
  end

  // Event output pulse, one clock wide, gated by enable and cause
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_out_r <= 1'b0;
    end else begin
      ev_out_r <= HAS_EVOUT && cfg.channel_event_output_enable
                  && (((cfg.event_output_cause_select == dcev_pkg::EVO_CAUSE_BLOCK)
                       && xfer.block_done)
                      || ((cfg.event_output_cause_select == dcev_pkg::EVO_CAUSE_BEAT)
                          && xfer.beat_done));
    end
  end

  assign ev_ack = ack_r;
  assign channel_suspend_flag_flag = channel_suspend_flag_flag_r;
  assign suspended = (state_r == dcev_pkg::DCEV_SUSPENDED);
  assign hold_req = (state_r != dcev_pkg::DCEV_RUN);
  assign ev_out = ev_out_r;

endmodule // dcev_chan

`default_nettype wire

// ===== hw/dcev_top.sv
// Top of the DMA channel event control block: reset sync and channel array
//
// Functional notes
// - Suspend event suspends the channel's transfer.
// - Suspend acknowledged after current bus access ends.
// - Resume event restarts a suspended channel.
// - Resume acknowledged at once, suspend flag cleared.
// - Skip event cancels next block suspend.
// - Skip while suspended resumes and acknowledges.
// - Early skip held until next block suspend.
// - Consumed skip continues channel, acknowledges event.
// - Only lowest channels carry event outputs.
// - Event output pulse is one clock wide.
// - Output events only when enable bit set.
// - Cause 0x1 per block, 0x3 per beat.
`timescale 1ns/10ps
`default_nettype none

module dcev_top #(
  parameter int unsigned NCH = dcev_pkg::NUM_CHANNELS,
  parameter int unsigned NEVO = dcev_pkg::NUM_EVOUT_CHANNELS
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [NCH-1:0] EV_IN,
  input wire dcev_pkg::dcev_cfg_t [NCH-1:0] CFG,
  input wire dcev_pkg::dcev_xfer_t [NCH-1:0] XFER,
  output logic [NCH-1:0] EV_ACK,
  output logic [NCH-1:0] CHANNEL_SUSPEND_FLAG,
  output logic [NCH-1:0] CH_SUSPENDED,
  output logic [NCH-1:0] CH_HOLD,
  output logic [NEVO-1:0] EV_OUT
);

  logic rst_s1_r;
  logic rst_s2_r;
  logic [NCH-1:0] ev_out_all;

  // Reset release through two flip-flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel array; channels NEVO and above have their output tied off
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      dcev_chan #(
        .HAS_EVOUT(g < NEVO)
      ) u_chan (
        .clk(CORE_CLK),
        .rst_n(rst_s2_r),
        .ev_in(EV_IN[g]),
        .cfg(CFG[g]),
        .xfer(XFER[g]),
        .ev_ack(EV_ACK[g]),
        .channel_suspend_flag_flag(CHANNEL_SUSPEND_FLAG[g]),
        .suspended(CH_SUSPENDED[g]),
        .hold_req(CH_HOLD[g]),
        .ev_out(ev_out_all[g])
      );
    end
  endgenerate

  // Only the low channels reach the event network
  assign EV_OUT = ev_out_all[NEVO-1:0];

endmodule // dcev_top

`default_nettype wire

// ===== test/dcev_chk_sva.sv
// Assertion checker for the channel event control block, channel 0
`timescale 1ns/10ps
`default_nettype none
module dcev_chk_sva #(
  parameter int unsigned NCH = 12,
  parameter int unsigned NEVO = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [NCH-1:0] EV_IN,
  input wire dcev_pkg::dcev_cfg_t [NCH-1:0] CFG,
  input wire dcev_pkg::dcev_xfer_t [NCH-1:0] XFER,
  input wire logic [NCH-1:0] EV_ACK,
  input wire logic [NCH-1:0] CHANNEL_SUSPEND_FLAG,
  input wire logic [NCH-1:0] CH_SUSPENDED,
  input wire logic [NCH-1:0] CH_HOLD,
  input wire logic [NEVO-1:0] EV_OUT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////
  // Decoded channel 0 events and wanted output cause
  wire logic [1:0] act = CFG[0].evin_act;
  wire logic cs = CFG[0].event_output_cause_select == dcev_pkg::EVO_CAUSE_BLOCK;
  wire logic cb = CFG[0].event_output_cause_select == dcev_pkg::EVO_CAUSE_BEAT;
  wire logic want = CFG[0].channel_event_output_enable && (cs && XFER[0].block_done
    || cb && XFER[0].beat_done);
  wire logic wait_st = CH_HOLD[0] && !CH_SUSPENDED[0] && !EV_IN[0];
  property p_channel_suspend_flag; EV_IN[0] && act == 2'h1 && !CH_SUSPENDED[0] |=> CH_HOLD[0]; endproperty
  a_channel_suspend_flag: assert property (p_channel_suspend_flag) else $error("suspend not taken");
  property p_hold; CH_SUSPENDED[0] |-> CH_HOLD[0] && CHANNEL_SUSPEND_FLAG[0]; endproperty
  a_hold: assert property (p_hold) else $error("suspended without hold");
  property p_busy; wait_st && XFER[0].bus_busy |=> !EV_ACK[0] && !CH_SUSPENDED[0]; endproperty
  a_busy: assert property (p_busy) else $error("ack during bus access");
  property p_done; wait_st && !XFER[0].bus_busy |=> CH_SUSPENDED[0] && EV_ACK[0]; endproperty
  a_done: assert property (p_done) else $error("suspend ack late");
  property p_res; EV_IN[0] && act == 2'h2 && CH_SUSPENDED[0]
    |=> EV_ACK[0] && !CH_SUSPENDED[0] && !CHANNEL_SUSPEND_FLAG[0]; endproperty
  a_res: assert property (p_res) else $error("resume wrong");
  property p_skip; EV_IN[0] && act == 2'h3 && CH_SUSPENDED[0] |=> EV_ACK[0] && !CH_SUSPENDED[0];
  endproperty
  a_skip: assert property (p_skip) else $error("skip while suspended wrong");
  property p_blk; XFER[0].block_suspend && !CH_HOLD[0] && !EV_IN[0]
    |=> CH_SUSPENDED[0] ^ EV_ACK[0]; endproperty
  a_blk: assert property (p_blk) else $error("block suspend wrong");
  property p_evo; EV_OUT[0] == $past(want) && !(EV_OUT[0] && $past(EV_OUT[0], 1) && !cb);
  endproperty
  a_evo: assert property (p_evo) else $error("event output wrong");
  c_channel_suspend_flag: cover property ($rose(CH_SUSPENDED[0]));
  c_ack: cover property (EV_ACK[0]);
  c_out: cover property (EV_OUT[0]);
endmodule // dcev_chk_sva
`default_nettype wire

// ===== test/dcev_evnet_model.sv
// Event routing network model: one-cycle event pulses per channel
`timescale 1ns/10ps
`default_nettype none
module dcev_evnet_model #(
  parameter int unsigned NCH = 12
) (
  input wire logic clk,
  input wire logic [NCH-1:0] fire,
  output logic [NCH-1:0] ev
);
  // Registered so each request becomes a pulse in the core clock domain
  always_ff @(posedge clk) begin
    ev <= fire;
  end
endmodule // dcev_evnet_model
`default_nettype wire

// ===== test/test_dma_channel_event_control.sv
// Self-checking bench for the channel event control block
`timescale 1ns/10ps
`default_nettype none
module test_dma_channel_event_control;
  localparam int unsigned NCH = 12;
  localparam int unsigned NEVO = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NCH-1:0] fire = '0;
  logic [NCH-1:0] ev_in, ack, flag, channel_suspend_flag, hold;
  dcev_pkg::dcev_cfg_t [NCH-1:0] cfg = '0;
  dcev_pkg::dcev_xfer_t [NCH-1:0] xf = '0;
  logic [NEVO-1:0] ev_out;
  int n_errors = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  dcev_evnet_model #(.NCH(NCH)) u_net (.clk(clk), .fire(fire), .ev(ev_in));
  dcev_top #(.NCH(NCH), .NEVO(NEVO)) dut (.CORE_CLK(clk), .RST_N(rst_n), .EV_IN(ev_in),
    .CFG(cfg), .XFER(xf), .EV_ACK(ack), .CHANNEL_SUSPEND_FLAG(flag), .CH_SUSPENDED(channel_suspend_flag),
    .CH_HOLD(hold), .EV_OUT(ev_out));
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [1:0] act);
    @(posedge clk);
    fire[0] <= 1'b1;
    cfg[0].evin_act <= act;
    @(posedge clk);
    fire[0] <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic blk_channel_suspend_flag();
    @(posedge clk);
    xf[0].block_suspend <= 1'b1;
    @(posedge clk);
    xf[0].block_suspend <= 1'b0;
    #1;
  endtask
  task automatic t_channel_suspend_flag_res();
    @(posedge clk);
    xf[0].bus_busy <= 1'b1;
    send(dcev_pkg::EVIN_ACT_SUSPEND);
    chk(hold[0], 1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk(ack[0], 1'b0);
    chk(channel_suspend_flag[0], 1'b0);
    @(posedge clk);
    xf[0].bus_busy <= 1'b0;
    @(posedge clk);
    #1;
    chk(ack[0], 1'b1);
    chk(flag[0], 1'b1);
    send(dcev_pkg::EVIN_ACT_RESUME);
    chk(ack[0], 1'b1);
    chk(flag[0], 1'b0);
    chk(channel_suspend_flag[0], 1'b0);
  endtask
  task automatic t_skip();
    send(dcev_pkg::EVIN_ACT_SUSPEND);
    @(posedge clk);
    #1;
    chk(channel_suspend_flag[0], 1'b1);
    send(dcev_pkg::EVIN_ACT_SKIP);
    chk(ack[0], 1'b1);
    chk(channel_suspend_flag[0], 1'b0);
    send(dcev_pkg::EVIN_ACT_SKIP);
    chk(ack[0], 1'b0);
    blk_channel_suspend_flag();
    chk(ack[0], 1'b1);
    chk(channel_suspend_flag[0], 1'b0);
    blk_channel_suspend_flag();
    chk(channel_suspend_flag[0], 1'b1);
    send(dcev_pkg::EVIN_ACT_RESUME);
    chk(ack[0], 1'b1);
    chk(channel_suspend_flag[0], 1'b0);
    chk(flag[0], 1'b0);
  endtask
  task automatic t_out(input int ch, input logic en, input logic [1:0] c, input bit beat);
    @(posedge clk);
    cfg[ch].channel_event_output_enable <= en;
    cfg[ch].event_output_cause_select <= c;
    xf[ch].beat_done <= beat;
    xf[ch].block_done <= !beat;
    @(posedge clk);
    xf[ch] <= '0;
    #1;
    chk(ev_out[ch], en && c == (beat ? 2'h3 : 2'h1));
    @(posedge clk);
    #1;
    chk(ev_out[ch], 1'b0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_channel_suspend_flag_res();
    t_skip();
    for (int k = 0; k < 32; k++) t_out(k[4] ? 3 : 0, k[0], k[2:1], k[3]);
    // Two-descriptor chain: block event selected in the last descriptor only
    t_out(0, 1'b1, dcev_pkg::EVO_CAUSE_NONE, 1'b0);
    t_out(0, 1'b1, dcev_pkg::EVO_CAUSE_BLOCK, 1'b0);
    report_and_stop();
  end
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
endmodule // test_dma_channel_event_control
bind dcev_top dcev_chk_sva #(.NCH(NCH), .NEVO(NEVO)) u_chk (.CORE_CLK(CORE_CLK),
  .RST_N(RST_N), .EV_IN(EV_IN), .CFG(CFG), .XFER(XFER), .EV_ACK(EV_ACK),
  .CHANNEL_SUSPEND_FLAG(CHANNEL_SUSPEND_FLAG), .CH_SUSPENDED(CH_SUSPENDED),
  .CH_HOLD(CH_HOLD), .EV_OUT(EV_OUT));
`default_nettype wire
